/* hw/urs_channel.sv */
`timescale 1ns/1ps
`default_nettype none
// plain valid/ready FIFO; write side stalls when full, read side when empty
module urs_fifo
	import urs_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     clear,
	// filling side
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	// draining side
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [WIDTH-1:0]              out_data,
	// fill level
	output logic [$clog2(DEPTH+1)-1:0]    count
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("urs_fifo: DEPTH must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;
	assign in_ready  = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	// storage has no reset; only the pointers matter
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	// pointers and level
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + {{($clog2(DEPTH+1)-1){1'b0}}, push} - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
		end
	end
endmodule // urs_fifo

// one channel: register select, banking, tx path and summary register
module urs_channel
	import urs_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int PEERS      = 3
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             prescale_select_pin,
	// host bus
	input  wire logic             cs_n,
	input  wire logic [PEERS-1:0] peer_cs_n,
	input  wire logic             rd_n,
	input  wire logic             wr_n,
	input  wire logic [2:0]       addr,
	input  wire logic [7:0]       wdata,
	output logic [7:0]            rdata,
	// received bytes from the deserialiser
	input  wire logic             rx_byte_valid,
	output logic                  rx_byte_ready,
	input  wire logic [7:0]       rx_byte,
	// readiness of the sibling channels
	input  wire logic [PEERS-1:0] peer_rx_ready,
	input  wire logic [PEERS-1:0] peer_tx_ready,
	// modem lines {cd, ri, dsr, cts}, active high
	input  wire logic [3:0]       modem_lines,
	output logic                  rts_n,
	output logic                  dtr_n,
	// serial side and status
	output logic                  serial_out,
	output logic                  tx_space,
	output logic                  rx_ready_out
);
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	initial begin
		if (PEERS != 3)
			$error("urs_channel: summary register holds exactly four channels");
	end

	// registers
	logic [7:0]  irq_enable, line_control, modem_control, scratch, dll, divisor_high, enhanced_features, fifo_control;
	logic [7:0]  resume_char_one, resume_char_two, pause_char_one, pause_char_two, flow_threshold, trigger_levels;
	logic [3:0]  modem_q, modem_delta;
	logic        rd_q, wr_q, txclr_pulse, rxclr_pulse;
	// fifo wires
	logic        tx_valid, tx_pop, rx_valid;
	logic [7:0]  tx_head, rx_head;
	logic [CW-1:0] tx_count, rx_count;
	logic        tx_in_ready, rx_in_ready;

	// strobe edges: one access per strobe assertion
	wire any_cs     = ~cs_n | ~&peer_cs_n;
	wire rd_act     = ~rd_n & any_cs;
	wire wr_act     = ~wr_n & ~cs_n;
	wire rd_start   = rd_act & ~rd_q;
	wire wr_start   = wr_act & ~wr_q;

	// bank decode
	wire bank_enh   = (line_control == ENH_KEY);
	wire bank_div   = line_control[LCR_DIVISOR_ACCESS_BIT];
	wire enh_on     = enhanced_features[EFR_ENH];
	wire tcr_open   = enh_on & modem_control[MCR_TCR_EN];
	wire rdy_open   = any_cs & modem_control[MCR_RDY_EN] & ~modem_control[MCR_LOOP];
	wire sel_div    = bank_div & (addr == SLOT_DATA || addr == SLOT_IER);
	wire sel_enh    = bank_enh & (addr == SLOT_IIR || addr[2]);
	wire bank_norm  = ~sel_div & ~sel_enh;
	wire sel_tcr    = bank_norm & tcr_open & (addr == SLOT_MSR);
	wire sel_tlr    = bank_norm & tcr_open & (addr == SLOT_SCRATCH);
	wire sel_rdy    = bank_norm & ~tcr_open & rdy_open & (addr == SLOT_SCRATCH);
	// own select is needed except for the shared summary register
	wire rd_take    = rd_start & (~cs_n | sel_rdy);
	wire wr_here    = wr_start & bank_norm & ~sel_tcr & ~sel_tlr;
	wire tx_write   = wr_here & (addr == SLOT_DATA);

	// status words
	wire fifo_en    = fifo_control[FCR_EN];
	wire tx_empty   = (tx_count == '0);
	logic        tsr_busy;
	wire [3:0] iir_code = (irq_enable[0] & rx_valid) ? IIR_RXDATA :
	                      (irq_enable[1] & tx_empty) ? IIR_THRE : IIR_NONE;
	wire [7:0] iir_val  = {fifo_en, fifo_en, 2'b00, iir_code};
	wire [7:0] lsr_val  = {1'b0, tx_empty & ~tsr_busy, tx_empty, 4'h0, rx_valid};
	wire [7:0] msr_val  = {modem_q, modem_delta};
	wire [7:0] rdy_val  = {peer_rx_ready, rx_valid, peer_tx_ready, tx_in_ready};

	// read selection
	wire [7:0] enh_rd   = (addr == SLOT_IIR) ? enhanced_features :
	                      (addr == SLOT_MCR) ? resume_char_one :
	                      (addr == SLOT_LSR) ? resume_char_two :
	                      (addr == SLOT_MSR) ? pause_char_one : pause_char_two;
	wire [7:0] div_rd   = (addr == SLOT_DATA) ? dll : divisor_high;
	wire [7:0] slot7_rd = sel_tlr ? trigger_levels : (sel_rdy ? rdy_val : scratch);
	wire [7:0] slot6_rd = sel_tcr ? flow_threshold : msr_val;
	wire [7:0] norm_rd  = (addr == SLOT_DATA) ? rx_head :
	                      (addr == SLOT_IER)  ? irq_enable :
	                      (addr == SLOT_IIR)  ? iir_val :
	                      (addr == SLOT_LCR)  ? line_control :
	                      (addr == SLOT_MCR)  ? modem_control :
	                      (addr == SLOT_LSR)  ? lsr_val :
	                      (addr == SLOT_MSR)  ? slot6_rd : slot7_rd;
	wire [7:0] rd_mux   = sel_enh ? enh_rd : (sel_div ? div_rd : norm_rd);
	wire rx_pop         = rd_take & bank_norm & (addr == SLOT_DATA) & ~cs_n;
	wire msr_clear      = rd_take & bank_norm & ~sel_tcr & (addr == SLOT_MSR);

	// strobe history and read data latch
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_q  <= 1'b0;
			wr_q  <= 1'b0;
			rdata <= RESET_BYTE;
		end else begin
			rd_q <= rd_act;
			wr_q <= wr_act;
			if (rd_take)
				rdata <= rd_mux;
		end
	end

	// normal bank writes; status slots five and six ignore writes
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_enable         <= RESET_BYTE;
			line_control         <= RESET_BYTE;
			scratch     <= RESET_BYTE;
			fifo_control         <= RESET_BYTE;
			txclr_pulse <= 1'b0;
			rxclr_pulse <= 1'b0;
		end else begin
			txclr_pulse <= 1'b0;
			rxclr_pulse <= 1'b0;
			if (wr_start && addr == SLOT_LCR)
				line_control <= wdata;
			if (wr_here && addr == SLOT_IER)
				irq_enable <= enh_on ? wdata : ((irq_enable & IER_ENH_MASK) | (wdata & ~IER_ENH_MASK));
			if (wr_here && addr == SLOT_SCRATCH)
				scratch <= wdata;
			if (wr_here && addr == SLOT_IIR) begin
				// transmit trigger bits are an enhanced function
				fifo_control <= (enh_on ? wdata : ((fifo_control & FCR_ENH_MASK) | (wdata & ~FCR_ENH_MASK))) & FCR_STORE;
				txclr_pulse <= wdata[FCR_TXCLR];
				rxclr_pulse <= wdata[FCR_RXCLR];
			end
		end
	end

	// modem control; prescale bit follows the pin while reset is held
	always_ff @(posedge clk) begin
		if (rst) begin
			modem_control <= {prescale_select_pin, 7'h00};
		end else if (wr_here && addr == SLOT_MCR) begin
			modem_control[6:0]            <= wdata[6:0];
			modem_control[MCR_PRESCALE]   <= enh_on ? wdata[MCR_PRESCALE] : modem_control[MCR_PRESCALE];
		end
	end

	// divisor, enhanced and flow registers
	always_ff @(posedge clk) begin
		if (rst) begin
			{dll, divisor_high, enhanced_features, resume_char_one, resume_char_two, pause_char_one, pause_char_two} <= {7{RESET_BYTE}};
			{flow_threshold, trigger_levels} <= {2{RESET_BYTE}};
		end else if (wr_start) begin
			if (sel_div && addr == SLOT_DATA)
				dll <= wdata;
			if (sel_div && addr == SLOT_IER)
				divisor_high <= wdata;
			if (sel_enh) begin
				unique case (addr)
					SLOT_IIR: enhanced_features   <= wdata;
					SLOT_MCR: resume_char_one  <= wdata;
					SLOT_LSR: resume_char_two  <= wdata;
					SLOT_MSR: pause_char_one <= wdata;
					default:  pause_char_two <= wdata;
				endcase
			end
			if (sel_tcr)
				flow_threshold <= wdata;
			if (sel_tlr)
				trigger_levels <= wdata;
		end
	end

	// modem change flags: a fresh change beats a read that clears
	always_ff @(posedge clk) begin
		if (rst) begin
			modem_q     <= 4'h0;
			modem_delta <= 4'h0;
		end else begin
			modem_q     <= modem_lines;
			modem_delta <= (msr_clear ? 4'h0 : modem_delta) | (modem_q ^ modem_lines);
		end
	end

	// transmit queue; without FIFO mode a single slot is used.
	// every write with room is queued whatever the shifter is doing, so
	// the old window before the start bit no longer loses bytes
	wire tx_room = tx_in_ready & (fifo_en | tx_empty);
	urs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk       (clk),
		.rst       (rst),
		.clear     (txclr_pulse),
		.in_valid  (tx_write & tx_room),
		.in_ready  (tx_in_ready),
		.in_data   (wdata),
		.out_valid (tx_valid),
		.out_ready (tx_pop),
		.out_data  (tx_head),
		.count     (tx_count)
	);
	assign tx_space = tx_room;

	// receive queue, stalls the deserialiser when full
	wire rx_room = rx_in_ready & (fifo_en | (rx_count == '0));
	urs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk       (clk),
		.rst       (rst),
		.clear     (rxclr_pulse),
		.in_valid  (rx_byte_valid & rx_room),
		.in_ready  (rx_in_ready),
		.in_data   (rx_byte),
		.out_valid (rx_valid),
		.out_ready (rx_pop),
		.out_data  (rx_head),
		.count     (rx_count)
	);
	assign rx_byte_ready = rx_room;
	assign rx_ready_out  = rx_valid;
	assign rts_n = ~modem_control[MCR_RTS];
	assign dtr_n = ~modem_control[MCR_DTR];

	// baud tick: total divisor is prescale factor times divisor latch
	logic [17:0] baud_cnt;
	wire  [15:0] divisor  = (({divisor_high, dll} == 16'h0000) ? 16'h0001 : {divisor_high, dll});
	wire  [17:0] total    = modem_control[MCR_PRESCALE] ? {divisor, 2'b00} : {2'b00, divisor};
	wire         tick     = (baud_cnt == 18'h0);
	always_ff @(posedge clk) begin
		if (rst)
			baud_cnt <= 18'h0;
		else
			baud_cnt <= tick ? total - 18'h1 : baud_cnt - 18'h1;
	end

	// transmit shifter, sixteen ticks per bit
	urs_tx_state_t tx_state;
	logic [5:0]  os_cnt;
	logic [2:0]  bit_idx;
	logic [7:0]  shreg;
	logic        par_acc;
	logic        tx_line;
	wire  [2:0]  last_bit  = {1'b1, line_control[1:0]};
	wire  [5:0]  stop_len  = ~line_control[LCR_STOP] ? TICKS_BIT :
	                         (line_control[1:0] == 2'b00) ? TICKS_STOP15 : TICKS_STOP2;
	wire  [5:0]  cur_len   = (tx_state == TX_STOP) ? stop_len : TICKS_BIT;
	wire         bit_done  = tick & (os_cnt == cur_len - 6'h1);
	assign tx_pop   = (tx_state == TX_IDLE) & tx_valid;
	assign tsr_busy = (tx_state != TX_IDLE);
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_state <= TX_IDLE;
			os_cnt   <= 6'h0;
			bit_idx  <= 3'h0;
			shreg    <= RESET_BYTE;
			par_acc  <= 1'b0;
			tx_line  <= 1'b1;
		end else begin
			if (tick)
				os_cnt <= bit_done ? 6'h0 : os_cnt + 6'h1;
			unique case (tx_state)
				TX_IDLE: begin
					tx_line <= 1'b1;
					os_cnt  <= 6'h0;
					if (tx_pop) begin
						shreg    <= tx_head;
						par_acc  <= ~line_control[LCR_EVEN];
						tx_line  <= 1'b0;
						tx_state <= TX_START;
					end
				end
				TX_START: if (bit_done) begin
					tx_line  <= shreg[0];
					par_acc  <= par_acc ^ shreg[0];
					shreg    <= shreg >> 1;
					bit_idx  <= 3'h0;
					tx_state <= TX_DATA;
				end
				TX_DATA: if (bit_done) begin
					bit_idx <= bit_idx + 3'h1;
					if (bit_idx == last_bit) begin
						tx_line  <= line_control[LCR_PAR_EN] ? par_acc : 1'b1;
						tx_state <= line_control[LCR_PAR_EN] ? TX_PARITY : TX_STOP;
					end else begin
						tx_line <= shreg[0];
						par_acc <= par_acc ^ shreg[0];
						shreg   <= shreg >> 1;
					end
				end
				TX_PARITY: if (bit_done) begin
					tx_line  <= 1'b1;
					tx_state <= TX_STOP;
				end
				TX_STOP: if (bit_done)
					tx_state <= TX_IDLE;
			endcase
		end
	end
	// break control forces the line low
	assign serial_out = tx_line & ~line_control[LCR_BREAK];

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_read_at(logic [2:0] slot);
		rd_take && addr == slot && bank_norm;
	endsequence
	sequence s_write_at(logic [2:0] slot);
		wr_start && addr == slot;
	endsequence
	property p_tx_accept;
		tx_write && tx_room && !tx_pop |=> tx_count == $past(tx_count) + 1'b1;
	endproperty
	a_tx_accept: assert property (p_tx_accept) else $error("tx write dropped");
	property p_iir_read;
		s_read_at(SLOT_IIR) |=> rdata == $past(iir_val);
	endproperty
	a_iir_read: assert property (p_iir_read) else $error("slot two read wrong");
	property p_fcr_write;
		s_write_at(SLOT_IIR) ##0 bank_norm |=> fifo_control[FCR_EN] == $past(wdata[FCR_EN]);
	endproperty
	a_fcr_write: assert property (p_fcr_write) else $error("fifo enable not stored");
	property p_lsr_ro;
		s_write_at(SLOT_LSR) ##0 bank_norm |=> $stable(line_control) && $stable(modem_control) && $stable(scratch);
	endproperty
	a_lsr_ro: assert property (p_lsr_ro) else $error("status slot written");
	property p_div_gate;
		s_write_at(SLOT_DATA) ##0 !line_control[LCR_DIVISOR_ACCESS_BIT] |=> $stable(dll);
	endproperty
	a_div_gate: assert property (p_div_gate) else $error("divisor written when closed");
	property p_efr_gate;
		s_write_at(SLOT_IIR) ##0 line_control != ENH_KEY |=> $stable(enhanced_features);
	endproperty
	a_efr_gate: assert property (p_efr_gate) else $error("enhanced reg written off key");
	property p_tcr_gate;
		s_write_at(SLOT_MSR) ##0 !(enhanced_features[EFR_ENH] && modem_control[MCR_TCR_EN]) |=> $stable(flow_threshold);
	endproperty
	a_tcr_gate: assert property (p_tcr_gate) else $error("threshold written when closed");
	property p_rdy_read;
		s_read_at(SLOT_SCRATCH) ##0 rdy_open && !tcr_open |=> rdata == $past(rdy_val);
	endproperty
	a_rdy_read: assert property (p_rdy_read) else $error("summary not read");
	property p_mcr7_lock;
		s_write_at(SLOT_MCR) ##0 !enhanced_features[EFR_ENH] |=> $stable(modem_control[MCR_PRESCALE]);
	endproperty
	a_mcr7_lock: assert property (p_mcr7_lock) else $error("prescale bit changed");
	// own disable: the check lives exactly on the reset release
	property p_prescale_pin;
		@(posedge clk) disable iff (1'b0)
			rst ##1 !rst |-> modem_control[MCR_PRESCALE] == $past(prescale_select_pin);
	endproperty
	a_prescale_pin: assert property (p_prescale_pin) else $error("pin not sampled");
endmodule // urs_channel
`default_nettype wire

/* hw/urs_pkg.sv */
// Behaviour
// - The three low address lines select one of eight slots; slot zero reads the oldest received byte and a write there queues a transmit byte.
// - Slot two reads interrupt identification, while a write to it updates the FIFO control settings.
// - In the normal bank slot five reads line status and slot six reads modem status, and writes there do nothing.
// - In the normal bank slots one, three, four and seven give read and write access to interrupt enable, line control, modem control and scratch.
// - The divisor low and high bytes sit at slots zero and one only while line control bit 7 is one.
// - Enhanced features at slot two and the resume and pause characters at slots four to seven are reached only while line control equals BF hex.
// - Flow threshold at slot six and trigger levels at slot seven are reached only while enhanced bit 4 and modem control bit 6 are both one.
// - The read-only FIFO-ready summary appears at slot seven when any channel select is low, modem control bit 2 is one and loopback is off.
// - Modem control bit 7 only changes on a write while enhanced bit 4 is set.
// - The prescale pin picks the divide factor during reset, and modem control bit 7 may change it afterwards.
// - The old defect dropped a second or third queued byte with FIFOs on, total divisor of four or more and one byte queued.
// - With divide-by-one and a divisor of one to three the defect never showed, so back-to-back writes are safe there.
// - In the enhanced bank slot two reads and writes enhanced features and slot zero gives the divisor low byte.
package urs_pkg;
	// register slots on the three address lines
	localparam logic [2:0] SLOT_DATA    = 3'h0;
	localparam logic [2:0] SLOT_IER     = 3'h1;
	localparam logic [2:0] SLOT_IIR     = 3'h2;
	localparam logic [2:0] SLOT_LCR     = 3'h3;
	localparam logic [2:0] SLOT_MCR     = 3'h4;
	localparam logic [2:0] SLOT_LSR     = 3'h5;
	localparam logic [2:0] SLOT_MSR     = 3'h6;
	localparam logic [2:0] SLOT_SCRATCH = 3'h7;
	// bank key and field positions
	localparam logic [7:0] ENH_KEY      = 8'hBF;
	localparam int LCR_DIVISOR_ACCESS_BIT    = 7;
	localparam int LCR_BREAK   = 6;
	localparam int LCR_EVEN    = 4;
	localparam int LCR_PAR_EN  = 3;
	localparam int LCR_STOP    = 2;
	localparam int MCR_PRESCALE= 7;
	localparam int MCR_TCR_EN  = 6;
	localparam int MCR_LOOP    = 4;
	localparam int MCR_RDY_EN  = 2;
	localparam int MCR_RTS     = 1;
	localparam int MCR_DTR     = 0;
	localparam int EFR_ENH     = 4;
	localparam int FCR_EN      = 0;
	localparam int FCR_RXCLR   = 1;
	localparam int FCR_TXCLR   = 2;
	// masks of bits writable only with enhanced functions on, and of the FIFO control bits that are stored
	localparam logic [7:0] IER_ENH_MASK = 8'hF0;
	localparam logic [7:0] FCR_ENH_MASK = 8'h30;
	localparam logic [7:0] FCR_STORE    = 8'hF9;
	// reset value and identification codes
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam logic [3:0] IIR_NONE     = 4'h1;
	localparam logic [3:0] IIR_THRE     = 4'h2;
	localparam logic [3:0] IIR_RXDATA   = 4'h4;
	// serial timing
	localparam int PRESCALE_FACTOR = 4;
	localparam logic [5:0] TICKS_BIT    = 6'h10;
	localparam logic [5:0] TICKS_STOP15 = 6'h18;
	localparam logic [5:0] TICKS_STOP2  = 6'h20;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} urs_tx_state_t;
endpackage

/* test/uart_register_select_and_tx_fifo_hazard_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_register_select_and_tx_fifo_hazard_tb_top;
	typedef struct packed {
		logic [7:0] line_control;
		logic [2:0] a;
		logic       w;
		logic [7:0] d;
		logic [7:0] e;
	} urs_row_t;
	// channel pins
	logic       clk, rst, pin, rx_v, rx_rdy, rx_out, ser, space, rts_n, dtr_n;
	logic       cs_n, rd_n, wr_n;
	logic [2:0] addr, prx, ptx;
	logic [7:0] wdata, rdata, rxb, q, b;
	logic [3:0] ml;
	int         err_total, n_compared, i, j, k, dv;
	logic [7:0] txb [3] = '{8'hA1, 8'hB2, 8'hC3};
	// line control, slot, write flag, data, expected read
	urs_row_t rows [22] = '{
		'{8'h00, 3'h2, 1'b0, 8'h00, 8'h01}, '{8'h00, 3'h2, 1'b1, 8'h01, 8'hC1},
		'{8'h00, 3'h7, 1'b1, 8'hA5, 8'hA5}, '{8'h00, 3'h1, 1'b1, 8'hFF, 8'h0F},
		'{8'h00, 3'h5, 1'b1, 8'hFF, 8'h60}, '{8'h00, 3'h6, 1'b1, 8'hFF, 8'h00},
		'{8'h80, 3'h0, 1'b1, 8'h12, 8'h12}, '{8'h80, 3'h1, 1'b1, 8'h34, 8'h34},
		'{8'hBF, 3'h2, 1'b1, 8'h10, 8'h10}, '{8'hBF, 3'h0, 1'b0, 8'h00, 8'h12},
		'{8'hBF, 3'h7, 1'b1, 8'h77, 8'h77}, '{8'h00, 3'h7, 1'b0, 8'h00, 8'hA5},
		'{8'h00, 3'h4, 1'b1, 8'hC0, 8'hC0}, '{8'h00, 3'h7, 1'b1, 8'h5A, 8'h5A},
		'{8'h00, 3'h4, 1'b1, 8'h00, 8'h00}, '{8'h00, 3'h7, 1'b0, 8'h00, 8'hA5},
		'{8'h00, 3'h4, 1'b1, 8'h04, 8'h04}, '{8'h00, 3'h7, 1'b0, 8'h00, 8'h69},
		'{8'h00, 3'h4, 1'b1, 8'h14, 8'h14}, '{8'h00, 3'h7, 1'b0, 8'h00, 8'hA5},
		'{8'hBF, 3'h2, 1'b1, 8'h00, 8'h00}, '{8'h00, 3'h4, 1'b1, 8'h80, 8'h00}
	};
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	urs_channel i_urs_channel (.clk(clk), .rst(rst), .prescale_select_pin(pin), .cs_n(cs_n),
		.peer_cs_n(3'h7), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata), .rdata(rdata),
		.rx_byte_valid(rx_v), .rx_byte_ready(rx_rdy), .rx_byte(rxb), .peer_rx_ready(prx),
		.peer_tx_ready(ptx), .modem_lines(ml), .rts_n(rts_n), .dtr_n(dtr_n),
		.serial_out(ser), .tx_space(space), .rx_ready_out(rx_out));
	urs_host i_urs_host (.clk(clk), .rdata(rdata), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.addr(addr), .wdata(wdata));
	// verdict and end of run
	task automatic print_verdict();
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// byte compare
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// reset held three cycles with the prescale pin steady
	task automatic reset_dut(input logic p);
		pin = p;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		#2;
		rst = 1'b0;
	endtask
	// hand one byte to the receive queue, bounded wait on room
	task automatic push_rx(input logic [7:0] v);
		int t;
		@(posedge clk);
		#2;
		rx_v = 1'b1;
		rxb = v;
		for (t = 0; t < 20 && rx_rdy !== 1'b1; t++) begin
			@(posedge clk);
			#2;
		end
		if (t == 20) begin
			err_total++;
			print_verdict();
		end
		@(posedge clk);
		#2;
		rx_v = 1'b0;
		rxb = ~v;
	endtask
	// sample one 8N1 frame at bit centres; returns in the stop bit
	task automatic ser_get(input int bt, output logic [7:0] v);
		int t;
		for (t = 0; t < 5000 && ser !== 1'b0; t++) @(posedge clk);
		if (t == 5000) begin
			err_total++;
			print_verdict();
		end
		repeat (bt / 2) @(posedge clk);
		for (t = 0; t < 8; t++) begin
			repeat (bt) @(posedge clk);
			v[t] = ser;
		end
		repeat (bt) @(posedge clk);
	endtask
	// main sequence
	initial begin
		{rst, pin, rx_v} = 3'h4;
		rxb = 8'h00;
		ml = 4'h0;
		prx = 3'h3;
		ptx = 3'h4;
		err_total = 0;
		n_compared = 0;
		reset_dut(1'b0);
		chk("reset_pins", 8'h0F, {4'h0, rts_n, dtr_n, ser, space});
		chk("reset_rdata", 8'h00, rdata);
		for (i = 0; i < 22; i++) begin
			i_urs_host.wr(3'h3, rows[i].line_control);
			if (rows[i].w) begin
				i_urs_host.wr(rows[i].a, rows[i].d);
			end
			i_urs_host.rd(rows[i].a, q);
			chk("row_read", rows[i].e, q);
		end
		// receive path: oldest byte at slot zero
		push_rx(8'h3C);
		chk("rx_ready", 8'h01, {7'h00, rx_out});
		i_urs_host.rd(3'h0, q);
		chk("rx_holding", 8'h3C, q);
		// modem line change shows with its delta flags, a read clears the flags
		ml = 4'h5;
		i_urs_host.rd(3'h6, q);
		chk("modem_status", 8'h55, q);
		i_urs_host.rd(3'h6, q);
		chk("modem_cleared", 8'h50, q);
		i_urs_host.wr(3'h4, 8'h03);
		chk("modem_pins", 8'h00, {6'h00, rts_n, dtr_n});
		// reset again: the table rows leave a slow divisor in the baud counter
		reset_dut(1'b0);
		chk("rerun_pins", 8'h0F, {4'h0, rts_n, dtr_n, ser, space});
		i_urs_host.wr(3'h2, 8'h01);
		// back-to-back writes at a safe then a hazard divisor, then spaced writes
		for (k = 0; k < 3; k++) begin
			dv = (k == 0) ? 1 : 4;
			i_urs_host.wr(3'h3, 8'h80);
			i_urs_host.wr(3'h0, dv[7:0]);
			i_urs_host.wr(3'h1, 8'h00);
			i_urs_host.wr(3'h3, 8'h03);
			fork
				for (j = 0; j < 3; j++) begin
					i_urs_host.wr(3'h0, txb[j]);
					if (k == 2)
						repeat (4 * dv) @(posedge clk);
				end
				for (i = 0; i < 3; i++) begin
					ser_get(16 * dv, b);
					chk("serial_byte", txb[i], b);
				end
			join
			repeat (16 * dv) @(posedge clk);
			i_urs_host.rd(3'h5, q);
			chk("tx_drained", 8'h60, q);
		end
		// prescale pin lands in modem control bit 7 during reset
		reset_dut(1'b1);
		i_urs_host.rd(3'h4, q);
		chk("prescale_pin", 8'h80, q);
		print_verdict();
	end
endmodule // uart_register_select_and_tx_fifo_hazard_tb_top
`default_nettype wire

/* test/urs_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the parallel bus; strobes move just after a rising edge
module urs_host (
	// clock and answer
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	// select and strobes
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	// address and data
	output logic [2:0]      addr,
	output logic [7:0]      wdata
);
	// idle bus from time zero
	initial begin
		{cs_n, rd_n, wr_n} = 3'h7;
		addr = 3'h0;
		wdata = 8'h00;
	end
	// one access held over exactly one taking edge, then one idle cycle follows
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		#2;
		cs_n = 1'b0;
		addr = a;
		wdata = d;
		if (w) begin
			wr_n = 1'b0;
		end else begin
			rd_n = 1'b0;
		end
		@(posedge clk);
		#2;
		{cs_n, rd_n, wr_n} = 3'h7;
		// released lines flip so a stale value never looks valid
		addr = ~a;
		wdata = ~d;
	endtask
	// register write
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask
	// register read; data settled a cycle after the taking edge
	task automatic rd(input logic [2:0] a, output logic [7:0] q);
		acc(1'b0, a, 8'h00);
		@(posedge clk);
		#2;
		q = rdata;
	endtask
endmodule // urs_host
`default_nettype wire
